// file: rtl/_unused_placeholder_removed.sv
// Empty design unit kept out of the build; no logic lives here.

// file: rtl/squfa_core.sv
// SPI slave front end with per-channel transmit and receive FIFOs.
//
// Behaviour
// - Register write: command then data bytes, address rises after each byte.
// - Register read: command then returned bytes, address rises after each.
// - FIFO write: command then bytes pushed in order to channel transmit FIFO.
// - FIFO read: command then bytes popped from channel receive FIFO.
// - Command bits 5:4 select channel one to four.
// - Command bits 3:0 give the starting register index.
// - Each channel enabled separately; disabled channel neither sends nor receives.
// - Transmit trigger raised while enabled and level below trigger point.
// - Receive trigger raised while enabled and level above trigger point.
// - Transmit FIFO disabled after reset; refuses data while disabled.
// - Transmit data leaves only while channel enabled, at once when enabled.
// - Receive FIFO stores only with channel and receive FIFO enabled.
// - Channel enabled, receive FIFO disabled: received characters discarded.
// - Transmit flush clears contents, counter, pointers; bit clears next clock.
// - Receive flush clears contents, counter, pointers; bit clears next clock.
// - Eight-bit transmit counter counts writes up and sent bytes down.
// - Transmit counter wraps 255 to 0; full flag tells full from empty.
// - Eight-bit receive counter counts stores up and host reads down.
// - Receive counter wraps 255 to 0; full flag tells full from empty.
// - Each channel has separate 256-entry transmit and receive FIFOs.
// - Trigger from two-bit field unless override level is nonzero.
`timescale 1ns/1ps
`default_nettype none

module squfa_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic                         flush,
    input  wire logic                         in_valid,
    output logic                              in_ready,
    input  wire logic [WIDTH-1:0]             in_data,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic [WIDTH-1:0]                  out_data,
    output logic [$clog2(DEPTH):0]            count
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } squfa_fifo_state_t;

    squfa_fifo_state_t st_r;
    squfa_fifo_state_t st_nxt;
    logic [WIDTH-1:0]  mem [DEPTH];
    logic              push;
    logic              pop;

    assign in_ready  = (st_r.count != (AW+1)'(DEPTH));
    assign out_valid = (st_r.count != '0);
    assign out_data  = mem[st_r.rd_ptr];
    assign count     = st_r.count;
    assign push      = in_valid & in_ready & ~flush;
    assign pop       = out_valid & out_ready & ~flush;

    always_comb begin
        st_nxt = st_r;
        if (flush) begin
            st_nxt = '0;
        end else begin
            if (push) begin
                st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
            end
            if (pop) begin
                st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
            end
            st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st_r.wr_ptr] <= in_data;
        end
    end
endmodule

module squfa_core
    import squfa_pkg::*;
(
    input  wire logic                                   sys_clk,
    input  wire logic                                   reset,
    input  wire logic                                   spi_sclk,
    input  wire logic                                   port_select_n,
    input  wire logic                                   serial_in,
    output logic                                        serial_out,
    output logic                                        serial_out_oe_n,
    output logic                                        reg_wr_en,
    output logic [squfa_pkg::CHAN_W-1:0]                reg_chan,
    output logic [squfa_pkg::REG_ADDR_W-1:0]            reg_index,
    output logic [squfa_pkg::DATA_W-1:0]                reg_wr_data,
    output logic                                        reg_rd_en,
    input  wire logic [squfa_pkg::DATA_W-1:0]           reg_rd_data,
    output logic                                        spi_wr_dropped,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         chan_enable,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         tx_fifo_enable,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         rx_fifo_enable,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         tx_flush,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         rx_flush,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         tx_trig_int_en,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         rx_trig_int_en,
    input  wire logic [squfa_pkg::CHANNELS-1:0][1:0]    tx_trig_sel,
    input  wire logic [squfa_pkg::CHANNELS-1:0][1:0]    rx_trig_sel,
    input  wire logic [squfa_pkg::CHANNELS-1:0][7:0]    tx_trigger_level,
    input  wire logic [squfa_pkg::CHANNELS-1:0][7:0]    rx_trigger_level,
    output logic [squfa_pkg::CHANNELS-1:0]              tx_trig_irq,
    output logic [squfa_pkg::CHANNELS-1:0]              rx_trig_irq,
    output logic [squfa_pkg::CHANNELS-1:0][7:0]         tx_count,
    output logic [squfa_pkg::CHANNELS-1:0][7:0]         rx_count,
    output logic [squfa_pkg::CHANNELS-1:0]              tx_full,
    output logic [squfa_pkg::CHANNELS-1:0]              tx_empty,
    output logic [squfa_pkg::CHANNELS-1:0]              rx_full,
    output logic [squfa_pkg::CHANNELS-1:0]              rx_empty,
    output logic [squfa_pkg::CHANNELS-1:0]              uart_tx_valid,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         uart_tx_ready,
    output logic [squfa_pkg::CHANNELS-1:0][7:0]         uart_tx_data,
    input  wire logic [squfa_pkg::CHANNELS-1:0]         uart_rx_valid,
    input  wire logic [squfa_pkg::CHANNELS-1:0][7:0]    uart_rx_data
);
    import squfa_pkg::*;

    localparam int CW = $clog2(CHAN_FIFO_DEPTH) + 1;

    typedef struct packed {
        squfa_state_t            state;
        logic [CHAN_W-1:0]       chan;
        logic [REG_ADDR_W-1:0]   addr;
        logic [2:0]              bit_cnt;
        logic [DATA_W-1:0]       shin;
        logic [DATA_W-1:0]       shout;
        logic                    out_bit;
        logic                    drive;
        logic                    fetch;
        logic                    sclk_q;
        logic                    reg_wr;
        logic                    reg_rd;
        logic [REG_ADDR_W-1:0]   wr_addr;
        logic [DATA_W-1:0]       wr_data;
        logic                    dropped;
        logic [CHANNELS-1:0]     tx_flush;
        logic [CHANNELS-1:0]     rx_flush;
    } squfa_core_state_t;

    // Override wins when nonzero, else the fixed table applies.
    function automatic logic [7:0] trig_point(input logic [7:0] override,
                                              input logic [1:0] sel,
                                              input logic       is_rx);
        logic [7:0] lvl;
        lvl = TRIG_LVL_0;
        if (override != 8'h00) begin
            lvl = override;
        end else begin
            unique case (sel)
                2'h0: lvl = TRIG_LVL_0;
                2'h1: lvl = TRIG_LVL_1;
                2'h2: lvl = TRIG_LVL_2;
                2'h3: lvl = is_rx ? RX_TRIG_LVL_3 : TX_TRIG_LVL_3;
            endcase
        end
        return lvl;
    endfunction

    squfa_core_state_t          c_r;
    squfa_core_state_t          c_nxt;
    logic                       rise;
    logic                       fall;
    logic                       byte_done;
    logic [DATA_W-1:0]          rx_byte;
    logic                       stage_push;
    logic                       stage_in_ready;
    logic                       stage_out_valid;
    logic                       stage_out_ready;
    logic [CHAN_W+DATA_W-1:0]   stage_out_data;
    logic [CHANNELS-1:0]        tx_in_ready;
    logic [CHANNELS-1:0]        rx_out_valid;
    logic [CHANNELS-1:0]        rx_pop;
    logic [CHANNELS-1:0][7:0]   rx_out_data;

    // Mode 0: sample on the rising edge, shift out on the falling edge.
    assign rise      = spi_sclk & ~c_r.sclk_q & ~port_select_n;
    assign fall      = ~spi_sclk & c_r.sclk_q & ~port_select_n;
    assign byte_done = rise & (c_r.bit_cnt == LAST_BIT);
    assign rx_byte   = {c_r.shin[DATA_W-2:0], serial_in};
    assign stage_push = byte_done & (c_r.state == ST_FIFO_WR);

    always_comb begin
        c_nxt          = c_r;
        c_nxt.sclk_q   = spi_sclk;
        c_nxt.reg_wr   = 1'b0;
        c_nxt.reg_rd   = 1'b0;
        c_nxt.fetch    = 1'b0;
        c_nxt.dropped  = stage_push & ~stage_in_ready;
        c_nxt.tx_flush = tx_flush;
        c_nxt.rx_flush = rx_flush;
        if (port_select_n) begin
            c_nxt.state   = ST_CMD;
            c_nxt.bit_cnt = 3'h0;
            c_nxt.drive   = 1'b0;
        end else begin
            if (rise) begin
                c_nxt.shin    = rx_byte;
                c_nxt.bit_cnt = c_r.bit_cnt + 3'h1;
            end
            if (byte_done) begin
                unique case (c_r.state)
                    ST_CMD: begin
                        c_nxt.chan = rx_byte[CMD_CHAN_HI:CMD_CHAN_LO];
                        c_nxt.addr = rx_byte[CMD_ADDR_HI:CMD_ADDR_LO];
                        unique case (rx_byte[CMD_OP_HI:CMD_OP_LO])
                            OP_REG_WR:  c_nxt.state = ST_REG_WR;
                            OP_REG_RD:  c_nxt.state = ST_REG_RD;
                            OP_FIFO_WR: c_nxt.state = ST_FIFO_WR;
                            OP_FIFO_RD: c_nxt.state = ST_FIFO_RD;
                        endcase
                        c_nxt.fetch = rx_byte[CMD_OP_LO];
                    end
                    ST_REG_WR: begin
                        c_nxt.reg_wr  = 1'b1;
                        c_nxt.wr_addr = c_r.addr;
                        c_nxt.wr_data = rx_byte;
                        c_nxt.addr    = c_r.addr + 4'h1;
                    end
                    ST_REG_RD, ST_FIFO_RD: begin
                        c_nxt.fetch = 1'b1;
                    end
                    ST_FIFO_WR: ;
                endcase
            end
            if (c_r.fetch) begin
                if (c_r.state == ST_REG_RD) begin
                    c_nxt.shout  = reg_rd_data;
                    c_nxt.reg_rd = 1'b1;
                    c_nxt.addr   = c_r.addr + 4'h1;
                end else begin
                    c_nxt.shout = rx_out_valid[c_r.chan] ?
                                  rx_out_data[c_r.chan] : EMPTY_RD_VALUE;
                end
            end
            if (fall) begin
                c_nxt.drive = (c_r.state == ST_REG_RD) ||
                              (c_r.state == ST_FIFO_RD);
                c_nxt.out_bit = c_r.shout[DATA_W-1];
                c_nxt.shout   = {c_r.shout[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            c_r       <= '0;
            c_r.state <= ST_CMD;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign serial_out      = c_r.out_bit;
    assign serial_out_oe_n = ~(c_r.drive & ~port_select_n);
    assign reg_wr_en       = c_r.reg_wr;
    assign reg_rd_en       = c_r.reg_rd;
    assign reg_chan        = c_r.chan;
    assign reg_index       = c_r.reg_wr ? c_r.wr_addr : c_r.addr;
    assign reg_wr_data     = c_r.wr_data;
    assign spi_wr_dropped  = c_r.dropped;

    // The link cannot be paused, so a full staging buffer drops the byte
    // and reports it; a full transmit FIFO backs up into this buffer.
    squfa_fifo #(
        .WIDTH (CHAN_W + DATA_W),
        .DEPTH (STAGE_DEPTH)
    ) u_stage (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .flush     (1'b0),
        .in_valid  (stage_push),
        .in_ready  (stage_in_ready),
        .in_data   ({c_r.chan, rx_byte}),
        .out_valid (stage_out_valid),
        .out_ready (stage_out_ready),
        .out_data  (stage_out_data),
        .count     ()
    );

    // A disabled transmit FIFO swallows its bytes rather than blocking all.
    assign stage_out_ready =
        ~tx_fifo_enable[stage_out_data[DATA_W +: CHAN_W]] |
        tx_in_ready[stage_out_data[DATA_W +: CHAN_W]];
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic [CW-1:0] tx_cnt;
        logic [CW-1:0] rx_cnt;
        logic          tx_push;
        logic          tx_out_valid;
        logic          rx_in_ready;
        logic          rx_push;
        assign tx_push = stage_out_valid & tx_fifo_enable[ch] &
            (stage_out_data[DATA_W +: CHAN_W] == CHAN_W'(ch));
        assign rx_push = uart_rx_valid[ch] & chan_enable[ch] &
                         rx_fifo_enable[ch];
        assign rx_pop[ch] = c_r.fetch & (c_r.state == ST_FIFO_RD) &
                            (c_r.chan == CHAN_W'(ch));
        squfa_fifo #(
            .WIDTH (DATA_W),
            .DEPTH (CHAN_FIFO_DEPTH)
        ) u_tx (
            .sys_clk   (sys_clk),
            .reset     (reset),
            .flush     (c_r.tx_flush[ch]),
            .in_valid  (tx_push),
            .in_ready  (tx_in_ready[ch]),
            .in_data   (stage_out_data[DATA_W-1:0]),
            .out_valid (tx_out_valid),
            .out_ready (uart_tx_ready[ch] & chan_enable[ch]),
            .out_data  (uart_tx_data[ch]),
            .count     (tx_cnt)
        );
        squfa_fifo #(
            .WIDTH (DATA_W),
            .DEPTH (CHAN_FIFO_DEPTH)
        ) u_rx (
            .sys_clk   (sys_clk),
            .reset     (reset),
            .flush     (c_r.rx_flush[ch]),
            .in_valid  (rx_push),
            .in_ready  (rx_in_ready),
            .in_data   (uart_rx_data[ch]),
            .out_valid (rx_out_valid[ch]),
            .out_ready (rx_pop[ch]),
            .out_data  (rx_out_data[ch]),
            .count     (rx_cnt)
        );
        assign uart_tx_valid[ch] = tx_out_valid & chan_enable[ch];
        assign tx_count[ch] = tx_cnt[7:0];
        assign rx_count[ch] = rx_cnt[7:0];
        assign tx_full[ch]  = ~tx_in_ready[ch];
        assign tx_empty[ch] = ~tx_out_valid;
        assign rx_full[ch]  = ~rx_in_ready;
        assign rx_empty[ch] = ~rx_out_valid[ch];
        assign tx_trig_irq[ch] = tx_trig_int_en[ch] & (tx_cnt <
            CW'(trig_point(tx_trigger_level[ch], tx_trig_sel[ch], 1'b0)));
        assign rx_trig_irq[ch] = rx_trig_int_en[ch] & (rx_cnt >
            CW'(trig_point(rx_trigger_level[ch], rx_trig_sel[ch], 1'b1)));
    end
endmodule

`default_nettype wire

// file: rtl/squfa_pkg.sv
// Shared constants and types of the quad UART SPI FIFO access block.
package squfa_pkg;

    localparam int CHANNELS        = 4;
    localparam int DATA_W          = 8;
    localparam int CHAN_FIFO_DEPTH = 256;
    localparam int STAGE_DEPTH     = 16;
    localparam int REG_ADDR_W      = 4;
    localparam int CHAN_W          = 2;
    localparam int LEVEL_W         = 8;

    // Command byte layout.
    localparam int CMD_OP_HI   = 7;
    localparam int CMD_OP_LO   = 6;
    localparam int CMD_CHAN_HI = 5;
    localparam int CMD_CHAN_LO = 4;
    localparam int CMD_ADDR_HI = 3;
    localparam int CMD_ADDR_LO = 0;

    localparam logic [1:0] OP_REG_WR  = 2'h0;
    localparam logic [1:0] OP_REG_RD  = 2'h1;
    localparam logic [1:0] OP_FIFO_WR = 2'h2;
    localparam logic [1:0] OP_FIFO_RD = 2'h3;

    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam logic [7:0] EMPTY_RD_VALUE = 8'h00;

    // Fixed trigger points selected by the two-bit field.
    localparam logic [7:0] TRIG_LVL_0    = 8'h08;
    localparam logic [7:0] TRIG_LVL_1    = 8'h10;
    localparam logic [7:0] TRIG_LVL_2    = 8'h18;
    localparam logic [7:0] TX_TRIG_LVL_3 = 8'h1E;
    localparam logic [7:0] RX_TRIG_LVL_3 = 8'h1C;

    typedef enum logic [4:0] {
        ST_CMD     = 5'h01,
        ST_REG_WR  = 5'h02,
        ST_REG_RD  = 5'h04,
        ST_FIFO_WR = 5'h08,
        ST_FIFO_RD = 5'h10
    } squfa_state_t;

endpackage

// file: test/squfa_core_sva.sv
// Concurrent checks on the ports of the SPI FIFO access core.
`timescale 1ns/1ps
`default_nettype none
module squfa_core_sva (
    input wire logic            sys_clk,
    input wire logic            reset,
    input wire logic            port_select_n,
    input wire logic            serial_out_oe_n,
    input wire logic            reg_wr_en,
    input wire logic            reg_rd_en,
    input wire logic [3:0]      chan_enable,
    input wire logic [3:0]      rx_fifo_enable,
    input wire logic [3:0]      uart_tx_valid,
    input wire logic [3:0]      uart_rx_valid,
    input wire logic [3:0]      tx_flush,
    input wire logic [3:0]      tx_empty,
    input wire logic [3:0]      tx_full,
    input wire logic [3:0]      rx_full,
    input wire logic [3:0]      tx_trig_int_en,
    input wire logic [3:0]      rx_trig_int_en,
    input wire logic [3:0]      tx_trig_irq,
    input wire logic [3:0]      rx_trig_irq,
    input wire logic [3:0][1:0] tx_trig_sel,
    input wire logic [3:0][1:0] rx_trig_sel,
    input wire logic [3:0][7:0] tx_trigger_level,
    input wire logic [3:0][7:0] rx_trigger_level,
    input wire logic [3:0][7:0] tx_count,
    input wire logic [3:0][7:0] rx_count
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [3:0] tx_exp;
    logic [3:0] rx_exp;

    function automatic logic [8:0] trig(logic [1:0] s, logic [7:0] o,
                                        logic rx);
        if (o != 8'h00)
            return {1'b0, o};
        case (s)
            2'h0: return 9'h008;
            2'h1: return 9'h010;
            2'h2: return 9'h018;
            default: return rx ? 9'h01C : 9'h01E;
        endcase
    endfunction

    // A zero count with the full flag set stands for 256 entries.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            tx_exp[i] = tx_trig_int_en[i] && ({tx_full[i], tx_count[i]}
                < trig(tx_trig_sel[i], tx_trigger_level[i], 1'b0));
            rx_exp[i] = rx_trig_int_en[i] && ({rx_full[i], rx_count[i]}
                > trig(rx_trig_sel[i], rx_trigger_level[i], 1'b1));
        end
    end

    chk_oe_idle: assert property (
        port_select_n [*2] |-> serial_out_oe_n)
        else $error("serial output driven while deselected");
    chk_wr_quiet: assert property (reg_wr_en |-> serial_out_oe_n)
        else $error("serial output driven in a write");
    chk_rd_drive: assert property (
        reg_rd_en |-> ##[0:40] !serial_out_oe_n)
        else $error("read data never driven");
    chk_wr_pulse: assert property (reg_wr_en |=> !reg_wr_en)
        else $error("register write strobe too long");
    chk_tx_gate: assert property (
        (uart_tx_valid & ~chan_enable) == 4'h0)
        else $error("disabled channel offers transmit data");
    chk_tx_irq: assert property (tx_trig_irq == tx_exp)
        else $error("transmit trigger flag wrong");
    chk_rx_irq: assert property (rx_trig_irq == rx_exp)
        else $error("receive trigger flag wrong");
    chk_tx_flush: assert property (tx_flush != 4'h0 |-> ##2
        (tx_empty & $past(tx_flush, 2)) == $past(tx_flush, 2))
        else $error("transmit flush did not empty the buffer");
    chk_rx_store: assert property (uart_rx_valid[0] && chan_enable[0]
        && rx_fifo_enable[0] && !rx_full[0] && port_select_n
        |=> rx_count[0] == $past(rx_count[0]) + 8'h01)
        else $error("received byte not counted");
    chk_rx_drop: assert property (uart_rx_valid[0] && !rx_fifo_enable[0]
        && port_select_n |=> $stable(rx_count[0]))
        else $error("byte stored with receive buffer off");

    cover property (reg_rd_en);
    cover property (rx_full[0] || rx_full[1]);
    cover property (tx_full[2]);
endmodule
bind squfa_core squfa_core_sva chk (.*);
`default_nettype wire

// file: test/squfa_core_tb.sv
// Self-checking bench of the quad UART SPI FIFO access core.
`timescale 1ns/1ps
`default_nettype none
module squfa_core_tb;
    logic            sys_clk, reset, spi_sclk, port_select_n, serial_in;
    logic            serial_out, serial_out_oe_n, reg_wr_en, reg_rd_en;
    logic            spi_wr_dropped;
    logic [1:0]      reg_chan;
    logic [3:0]      reg_index;
    logic [7:0]      reg_wr_data, reg_rd_data;
    logic [3:0]      chan_enable, tx_fifo_enable, rx_fifo_enable;
    logic [3:0]      tx_flush, rx_flush, tx_trig_int_en, rx_trig_int_en;
    logic [3:0]      tx_trig_irq, rx_trig_irq, tx_full, tx_empty, rx_full;
    logic [3:0]      rx_empty, uart_tx_valid, uart_rx_valid;
    logic [3:0]      uart_tx_ready = 4'h0;
    logic [3:0][1:0] tx_trig_sel, rx_trig_sel;
    logic [3:0][7:0] tx_trigger_level, rx_trigger_level, tx_count;
    logic [3:0][7:0] rx_count, uart_tx_data, uart_rx_data;
    logic [7:0]      regs[4][16];
    logic [7:0]      txq[4][$];
    logic [7:0]      rxq[4][$];
    logic [7:0]      snd[$];
    logic [7:0]      got[$];
    logic [13:0]     wq[$];
    int              mismatches = 0;
    int              checks_done = 0;

    squfa_core dut (.*);
    squfa_host host (.*);
    assign reg_rd_data = regs[reg_chan][reg_index];

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) #2 uart_tx_ready = 4'($urandom);

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic fill(int n);
        snd = {};
        repeat (n) snd.push_back(8'($urandom));
    endtask
    task automatic spi(logic [7:0] cmd, logic [7:0] tx[$]);
        logic [7:0] r;
        got = {};
        host.start();
        host.xfer(cmd, r);
        foreach (tx[i]) begin
            host.xfer(tx[i], r);
            got.push_back(r);
        end
        host.stop();
    endtask
    task automatic fwr(int c, int n, logic keep);
        fill(n);
        if (keep) txq[c] = {txq[c], snd};
        spi({2'h2, 2'(c), 4'($urandom)}, snd);
    endtask
    task automatic rx_push(int c, logic [7:0] d, logic keep);
        tick(1);
        uart_rx_valid[c] = 1'b1;
        uart_rx_data[c] = d;
        if (keep) rxq[c].push_back(d);
        tick(1);
        uart_rx_valid[c] = 1'b0;
    endtask

    always @(posedge sys_clk) begin
        if (reg_wr_en)
            check("reg write", 16'({reg_chan, reg_index, reg_wr_data}),
                  16'(wq.pop_front()));
        for (int c = 0; c < 4; c++)
            if (uart_tx_valid[c] && uart_tx_ready[c])
                check("tx byte", 16'(uart_tx_data[c]),
                      16'(txq[c].pop_front()));
        if (spi_wr_dropped)
            check("wr dropped", 16'h1, 16'h0);
    end

    initial begin
        void'($urandom(13178));
        reset = 1'b1;
        {chan_enable, tx_fifo_enable, rx_fifo_enable} = 12'h000;
        {tx_flush, rx_flush, uart_rx_valid} = 12'h000;
        uart_rx_data = 32'h0;
        {tx_trig_int_en, rx_trig_int_en} = 8'hFA;
        tx_trig_sel = 8'($urandom);
        rx_trig_sel = 8'($urandom);
        tx_trigger_level = {24'h0, 8'($urandom_range(255, 1))};
        rx_trigger_level = {8'h03, 24'h0};
        repeat (20) @(posedge sys_clk);
        #2 reset = 1'b0;
        tick(1);
        check("idle", {tx_empty, rx_empty, 7'h0, serial_out_oe_n}, 16'hFF01);
        for (int c = 0; c < 4; c++) begin
            fill(3);
            for (int k = 0; k < 3; k++) begin
                regs[c][4'hE + 4'(k)] = snd[k];
                wq.push_back({2'(c), 4'hE + 4'(k), snd[k]});
            end
            spi({2'h0, 2'(c), 4'hE}, snd);
        end
        check("write count", 16'(wq.size()), 16'h0);
        for (int c = 0; c < 4; c++) begin
            host.half = 4 + 4 * (c % 2);
            fill(3);
            spi({2'h1, 2'(c), 4'hE}, snd);
            for (int k = 0; k < 3; k++)
                check("reg read", 16'(got[k]), 16'(regs[c][4'hE + 4'(k)]));
        end
        host.half = 4;
        fwr(1, 2, 1'b0);
        tick(40);
        check("tx fifo off", 16'(tx_empty), 16'h000F);
        tx_fifo_enable = 4'hF;
        for (int c = 0; c < 4; c++)
            fwr(c, 5, 1'b1);
        tick(40);
        check("tx levels", 16'({tx_count[3], tx_count[0]}), 16'h0505);
        fwr(2, 251, 1'b0);
        tick(40);
        check("tx wrap", {tx_count[2], 4'(tx_full), 4'(tx_empty)}, 16'h0040);
        tx_flush = 4'h4;
        tick(1);
        tx_flush = 4'h0;
        tick(1);
        check("tx flush", 16'({tx_count[2], 4'(tx_empty)}), 16'h0004);
        txq[2] = {};
        chan_enable = 4'hF;
        tick(100);
        check("tx drained", 16'({tx_empty,
              4'(txq[0].size() + txq[3].size())}), 16'h00F0);
        chan_enable = 4'h7;
        rx_fifo_enable = 4'hE;
        rx_push(0, 8'h5A, 1'b0);
        rx_push(3, 8'hA5, 1'b0);
        tick(2);
        check("rx dropped", 16'(rx_empty), 16'h000F);
        chan_enable = 4'hF;
        rx_fifo_enable = 4'hF;
        for (int c = 0; c < 4; c++)
            repeat (4) rx_push(c, 8'($urandom), 1'b1);
        tick(2);
        check("rx levels", 16'({rx_count[2], rx_count[1]}), 16'h0404);
        for (int c = 0; c < 4; c++) begin
            fill(5);
            spi({2'h3, 2'(c), 4'(c)}, snd);
            rxq[c].push_back(8'h00);
            foreach (got[k])
                check("fifo read", 16'(got[k]), 16'(rxq[c][k]));
        end
        check("rx drained", 16'(rx_empty), 16'h000F);
        repeat (256) rx_push(1, 8'($urandom), 1'b0);
        tick(2);
        check("rx wrap", 16'({rx_count[1], 4'(rx_full)}), 16'h0002);
        // The byte after the last one clocked out is fetched early as well.
        fill(2);
        spi({2'h3, 2'h1, 4'h0}, snd);
        check("rx count down", 16'(rx_count[1]), 16'h00FD);
        rx_flush = 4'h2;
        tick(1);
        rx_flush = 4'h0;
        tick(1);
        check("rx flush", 16'({rx_count[1], 4'(rx_empty)}), 16'h000F);
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire

// file: test/squfa_host.sv
// SPI master host model that drives the slave port in mode 0.
`timescale 1ns/1ps
`default_nettype none
module squfa_host (
    input wire logic sys_clk,
    output logic     spi_sclk,
    output logic     port_select_n,
    output logic     serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    int half = 4;
    initial begin
        spi_sclk = 1'b0;
        port_select_n = 1'b1;
        serial_in = 1'b1;
    end
    task automatic start();
        @(posedge sys_clk);
        #2 port_select_n = 1'b0;
    endtask
    // Data changes while the clock is low and is sampled on its rise.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            @(posedge sys_clk);
            #2 spi_sclk = 1'b0;
            serial_in = tx[b];
            repeat (half) @(posedge sys_clk);
            #2 spi_sclk = 1'b1;
            rx[b] = serial_out_oe_n ? 1'bx : serial_out;
            repeat (half - 1) @(posedge sys_clk);
        end
    endtask
    // A released data line must not keep showing its last bit.
    task automatic stop();
        @(posedge sys_clk);
        #2 spi_sclk = 1'b0;
        repeat (half) @(posedge sys_clk);
        #2 port_select_n = 1'b1;
        serial_in = ~serial_in;
    endtask
endmodule
`default_nettype wire
